/* hdl/mcsi_map.svh */
// mcsi_map.svh: constants of the mcu system integration block
// assumes: included by its bare name before the package and the design
//
// Function
// - 109 instructions; 26 one-clock, 50 two-clock
// - only four exceed four clocks; max eight
// - twenty-one peripheral interrupt sources reach core
// - seven sources assert internal reset
// - reset pin bidirectional; power-on reset driven out
// - each source maskable except supply monitor, pin
// - watchdog lockable on after power-on reset
// - internal oscillator selected after any reset
// - software switches clock source without reset
// - upper data: indirect to ram, direct to sfr
// - lower half both modes; four register banks
// - sixteen bytes after banks are bit addressable
// - 2048-byte xram aliases over 64k space
// - flash erased/written in-system, 512-byte sectors
// - 0x7E00 to 0x7FFF reserved, not usable
// - extra 128-byte sector at 0x8000 to 0x807F
// - peripherals except adc freeze during debug halt
// - debug uses no application resources
// - test port follows boundary-scan standard
`ifndef MCSI_MAP_SVH
`define MCSI_MAP_SVH
`define MCSI_NUM_INSTR 109
`define MCSI_NUM_1CLK 26
`define MCSI_NUM_2CLK 50
`define MCSI_MAX_CLKS 4'h8
`define MCSI_IRQ_SRCS 21
`define MCSI_UPPER_BASE 8'h80
`define MCSI_BANK_END 8'h20
`define MCSI_BIT_END 8'h30
`define MCSI_XRAM_BITS 11
`define MCSI_SECTOR_BITS 9
`define MCSI_RSV_LO 16'h7E00
`define MCSI_RSV_HI 16'h7FFF
`define MCSI_XSEC_LO 16'h8000
`define MCSI_XSEC_HI 16'h807F
`define MCSI_POR_CYCLES 8'h10
`define MCSI_CLK_INT 1'b0
`define MCSI_CLK_EXT 1'b1
`endif

/* hdl/mcsi_pkg.sv */
// mcsi_pkg.sv: types of the mcu system integration block
// assumes: mcsi_map.svh holds the map numbers; field widths and encodings are written here
`include "mcsi_map.svh"
package mcsi_pkg;
  typedef enum logic [1:0] {
    MCSI_DS_LOWRAM = 2'b00,
    MCSI_DS_UPRAM = 2'b01,
    MCSI_DS_SFR = 2'b10
  } mcsi_dspace_t;
  typedef enum logic [1:0] {
    MCSI_PM_APP = 2'b00,
    MCSI_PM_RSV = 2'b01,
    MCSI_PM_XSEC = 2'b10,
    MCSI_PM_NONE = 2'b11
  } mcsi_pspace_t;
  typedef enum logic [1:0] {
    MCSI_EX_IDLE = 2'b00,
    MCSI_EX_RUN = 2'b01
  } mcsi_exst_t;
  // one bit per reset source, high to low
  typedef struct packed {
    logic pin;
    logic cnvst;
    logic sw;
    logic cmp0;
    logic mclk;
    logic wdog;
    logic vdd;
  } mcsi_rstsrc_t;
  typedef struct packed {
    logic [7:0] por_cnt;
    logic por_done;
    logic wdog_lock;
    logic clk_sel;
    mcsi_exst_t exst;
    logic [3:0] cyc_left;
    logic [3:0] cyc_total;
    logic instr_done;
    logic [20:0] irq_pend;
    logic rst_out;
  } mcsi_state_t;
endpackage

/* hdl/mcsi_top.sv */
// mcsi_top.sv: reset, clock select, cycle timing, memory decode, debug freeze
// assumes: one clock, all inputs synchronous to ref_clk
`include "mcsi_map.svh"
module mcsi_top import mcsi_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // reset sources, active high
  input wire mcsi_rstsrc_t rst_src,
  input wire mcsi_rstsrc_t rst_enable,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic core_rst,
  input wire logic wdog_lock_req,
  output logic wdog_locked,
  input wire logic clk_sel_wr,
  input wire logic clk_sel_val,
  output logic clk_sel,
  // instruction timing
  input wire logic instr_start,
  input wire logic [3:0] instr_lo,
  input wire logic [3:0] instr_hi,
  input wire logic instr_branch,
  output logic instr_busy,
  output logic instr_done,
  output logic [3:0] instr_cycles,
  // interrupts
  input wire logic [20:0] irq_src,
  input wire logic [20:0] irq_ack,
  output logic [20:0] irq_pend,
  // data memory decode
  input wire logic [7:0] dmem_addr,
  input wire logic dmem_indirect,
  output mcsi_dspace_t dmem_space,
  output logic dmem_bank_reg,
  output logic dmem_bitaddr,
  input wire logic [15:0] xmem_addr,
  output logic [10:0] xram_addr,
  // program memory decode
  input wire logic [15:0] pmem_addr,
  output mcsi_pspace_t pmem_space,
  output logic pmem_app_ok,
  output logic [6:0] pmem_sector,
  // debug
  input wire logic dbg_halt,
  input wire logic dbg_step,
  input wire logic dbg_break,
  output logic periph_freeze,
  output logic adc_run
);
  mcsi_state_t st;
  mcsi_state_t next_st;
  logic any_rst;
  logic frozen;

  // ----------------------------------------
  // reset gating function
  // ----------------------------------------
  // supply monitor and the pin source bypass every enable
  function automatic logic rst_gate(input mcsi_rstsrc_t src, input mcsi_rstsrc_t en, input logic lock);
    logic masked;
    masked = (src.wdog & (en.wdog | lock)) | (src.mclk & en.mclk) | (src.cmp0 & en.cmp0)
      | (src.sw & en.sw) | (src.cnvst & en.cnvst);
    rst_gate = src.vdd | src.pin | masked;
  endfunction

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic mcsi_pspace_t pdec(input logic [15:0] a);
    if (a >= `MCSI_RSV_LO && a <= `MCSI_RSV_HI) begin
      pdec = MCSI_PM_RSV;
    end else if (a < `MCSI_RSV_LO) begin
      pdec = MCSI_PM_APP;
    end else if (a >= `MCSI_XSEC_LO && a <= `MCSI_XSEC_HI) begin
      pdec = MCSI_PM_XSEC;
    end else begin
      pdec = MCSI_PM_NONE;
    end
  endfunction

  // ----------------------------------------
  // reset aggregation
  // ----------------------------------------
  // supply monitor and pin cannot be masked
  // own power-on drive loops back through the pin, so the core stays held
  assign any_rst = rst_gate(rst_src, rst_enable, st.wdog_lock) | rst_pin_in;
  assign frozen = dbg_halt | dbg_step | dbg_break;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.instr_done = 1'b0;
    if (!st.por_done) begin
      if (st.por_cnt == `MCSI_POR_CYCLES) begin
        next_st.por_done = 1'b1;
      end else begin
        next_st.por_cnt = st.por_cnt + 8'h01;
      end
    end
    next_st.rst_out = ~st.por_done;
    if (wdog_lock_req && st.por_done) begin
      next_st.wdog_lock = 1'b1;
    end
    if (clk_sel_wr) begin
      next_st.clk_sel = clk_sel_val;
    end
    next_st.irq_pend = (st.irq_pend & ~irq_ack) | irq_src;
    case (st.exst)
      MCSI_EX_IDLE: begin
        if (instr_start && !frozen) begin
          next_st.cyc_total = instr_branch ? instr_hi : instr_lo;
          if (next_st.cyc_total > `MCSI_MAX_CLKS) begin
            next_st.cyc_total = `MCSI_MAX_CLKS;
          end
          if (next_st.cyc_total == 4'h0) begin
            next_st.cyc_total = 4'h1;
          end
          next_st.cyc_left = next_st.cyc_total - 4'h1;
          if (next_st.cyc_left == 4'h0) begin
            next_st.instr_done = 1'b1;
          end else begin
            next_st.exst = MCSI_EX_RUN;
          end
        end
      end
      MCSI_EX_RUN: begin
        if (!frozen) begin
          next_st.cyc_left = st.cyc_left - 4'h1;
          if (st.cyc_left == 4'h1) begin
            next_st.instr_done = 1'b1;
            next_st.exst = MCSI_EX_IDLE;
          end
        end
      end
      default: begin
        next_st.exst = MCSI_EX_IDLE;
      end
    endcase
    if (any_rst) begin
      next_st.clk_sel = `MCSI_CLK_INT;
      next_st.exst = MCSI_EX_IDLE;
      next_st.cyc_left = 4'h0;
      next_st.irq_pend = 21'h000000;
      next_st.instr_done = 1'b0;
      next_st.wdog_lock = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = st.rst_out;
  assign core_rst = ~st.por_done | any_rst;
  assign wdog_locked = st.wdog_lock;
  assign clk_sel = st.clk_sel;
  assign instr_busy = (st.exst == MCSI_EX_RUN);
  assign instr_done = st.instr_done;
  assign instr_cycles = st.cyc_total;
  assign irq_pend = st.irq_pend;
  // upper half dual-mapped by addressing mode
  assign dmem_space = (dmem_addr < `MCSI_UPPER_BASE) ? MCSI_DS_LOWRAM
    : (dmem_indirect ? MCSI_DS_UPRAM : MCSI_DS_SFR);
  assign dmem_bank_reg = dmem_addr < `MCSI_BANK_END;
  assign dmem_bitaddr = dmem_addr >= `MCSI_BANK_END && dmem_addr < `MCSI_BIT_END;
  // partial decode: high bits ignored, so the block repeats
  assign xram_addr = xmem_addr[`MCSI_XRAM_BITS-1:0];
  assign pmem_space = pdec(pmem_addr);
  assign pmem_app_ok = pdec(pmem_addr) == MCSI_PM_APP || pdec(pmem_addr) == MCSI_PM_XSEC;
  assign pmem_sector = pmem_addr[15:`MCSI_SECTOR_BITS];
  // debug levels arrive already decoded by the test port logic
  // test port itself kept outside this block
  // freeze uses no application timer, ram or channel
  // adc keeps converting so analog timing is not disturbed
  assign periph_freeze = frozen;
  assign adc_run = 1'b1;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_clk_int;
    @(posedge ref_clk) disable iff (sys_rst) any_rst |=> clk_sel == `MCSI_CLK_INT;
  endproperty
  a_clk_int: assert property (p_clk_int) else $error("clock not internal after reset");
  property p_clk_sw;
    @(posedge ref_clk) disable iff (sys_rst) (clk_sel_wr && !any_rst) |=> clk_sel == $past(clk_sel_val);
  endproperty
  a_clk_sw: assert property (p_clk_sw) else $error("clock switch lost");
  property p_max;
    @(posedge ref_clk) disable iff (sys_rst) instr_busy |-> instr_cycles <= `MCSI_MAX_CLKS;
  endproperty
  a_max: assert property (p_max) else $error("instruction over eight clocks");
  property p_vdd;
    @(posedge ref_clk) disable iff (sys_rst) rst_src.vdd |-> core_rst;
  endproperty
  a_vdd: assert property (p_vdd) else $error("supply reset masked");
  property p_irq;
    @(posedge ref_clk) disable iff (sys_rst) (|irq_src && !any_rst) |=> (irq_pend & $past(irq_src)) == $past(irq_src);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt lost");
  property p_sfr;
    @(posedge ref_clk) disable iff (sys_rst) (dmem_addr[7] && !dmem_indirect) |-> dmem_space == MCSI_DS_SFR;
  endproperty
  a_sfr: assert property (p_sfr) else $error("direct upper not sfr");
  property p_rsv;
    @(posedge ref_clk) disable iff (sys_rst) (pmem_addr[15:9] == 7'h3F) |-> !pmem_app_ok;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flash usable");
  property p_lock;
    @(posedge ref_clk) disable iff (sys_rst) (wdog_locked && !any_rst) |=> wdog_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("watchdog lock dropped");
  property p_frz;
    @(posedge ref_clk) disable iff (sys_rst) (instr_busy && dbg_halt && !any_rst) |=> $stable(st.cyc_left);
  endproperty
  a_frz: assert property (p_frz) else $error("core advanced while halted");

  property p_start_frz;
    @(posedge ref_clk) disable iff (sys_rst) (frozen && !instr_busy) |=> !instr_busy;
  endproperty
  a_start_frz: assert property (p_start_frz) else $error("start taken while frozen");

  property p_freeze;
    @(posedge ref_clk) disable iff (sys_rst) frozen |-> (periph_freeze && adc_run);
  endproperty
  a_freeze: assert property (p_freeze) else $error("peripherals not frozen");

  // ----------------------------------------
  // reset checks
  // ----------------------------------------
  property p_pin_rst;
    @(posedge ref_clk) disable iff (sys_rst) (rst_pin_in || rst_src.pin) |-> core_rst;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset masked");

  property p_por_oe;
    @(posedge ref_clk) disable iff (sys_rst) !st.por_done |=> rst_pin_oe;
  endproperty
  a_por_oe: assert property (p_por_oe) else $error("power-on reset not driven out");

  property p_oe_off;
    @(posedge ref_clk) disable iff (sys_rst) st.por_done |=> !rst_pin_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("reset pin still driven");

  property p_por_core;
    @(posedge ref_clk) disable iff (sys_rst) !st.por_done |-> core_rst;
  endproperty
  a_por_core: assert property (p_por_core) else $error("core free during power-on");

  property p_mask;
    @(posedge ref_clk) disable iff (sys_rst)
      (rst_enable == 7'h00 && !rst_src.vdd && !rst_src.pin && !rst_pin_in && !wdog_locked && st.por_done)
      |-> !core_rst;
  endproperty
  a_mask: assert property (p_mask) else $error("disabled source still resets");

  property p_lock_rst;
    @(posedge ref_clk) disable iff (sys_rst) (wdog_locked && rst_src.wdog) |-> core_rst;
  endproperty
  a_lock_rst: assert property (p_lock_rst) else $error("locked watchdog masked");

  property p_irq_rst;
    @(posedge ref_clk) disable iff (sys_rst) any_rst |=> irq_pend == 21'h000000;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("pending kept over reset");

  property p_clk_hold;
    @(posedge ref_clk) disable iff (sys_rst) (!clk_sel_wr && !any_rst) |=> $stable(clk_sel);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock source moved unasked");

  // ----------------------------------------
  // executor and interrupt acknowledge checks
  // ----------------------------------------
  property p_clamp;
    @(posedge ref_clk) disable iff (sys_rst) (instr_start && !instr_busy && !frozen && !any_rst)
      |=> (instr_cycles != 4'h0 && instr_cycles <= `MCSI_MAX_CLKS);
  endproperty
  a_clamp: assert property (p_clamp) else $error("cycle count out of range");

  property p_branch;
    @(posedge ref_clk) disable iff (sys_rst) (instr_start && !instr_busy && !frozen && !any_rst
      && instr_branch && instr_hi != 4'h0 && instr_hi <= `MCSI_MAX_CLKS) |=> instr_cycles == $past(instr_hi);
  endproperty
  a_branch: assert property (p_branch) else $error("taken branch not high count");

  property p_nobranch;
    @(posedge ref_clk) disable iff (sys_rst) (instr_start && !instr_busy && !frozen && !any_rst
      && !instr_branch && instr_lo != 4'h0 && instr_lo <= `MCSI_MAX_CLKS) |=> instr_cycles == $past(instr_lo);
  endproperty
  a_nobranch: assert property (p_nobranch) else $error("untaken branch not low count");

  property p_run_len;
    @(posedge ref_clk) disable iff (sys_rst) (instr_busy && !frozen && !any_rst && st.cyc_left == 4'h1)
      |=> instr_done;
  endproperty
  a_run_len: assert property (p_run_len) else $error("instruction ran long");

  property p_irq_ack;
    @(posedge ref_clk) disable iff (sys_rst) (irq_ack[0] && !irq_src[0] && !any_rst) |=> !irq_pend[0];
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("acked interrupt still pending");

  // ----------------------------------------
  // memory map checks
  // ----------------------------------------
  property p_upram;
    @(posedge ref_clk) disable iff (sys_rst) (dmem_addr[7] && dmem_indirect) |-> dmem_space == MCSI_DS_UPRAM;
  endproperty
  a_upram: assert property (p_upram) else $error("indirect upper not ram");

  property p_low;
    @(posedge ref_clk) disable iff (sys_rst) !dmem_addr[7] |-> dmem_space == MCSI_DS_LOWRAM;
  endproperty
  a_low: assert property (p_low) else $error("lower half misrouted");

  property p_bank;
    @(posedge ref_clk) disable iff (sys_rst) (dmem_addr[7:5] == 3'h0) |-> (dmem_bank_reg && !dmem_bitaddr);
  endproperty
  a_bank: assert property (p_bank) else $error("bank area misdecoded");

  property p_bit;
    @(posedge ref_clk) disable iff (sys_rst) (dmem_addr[7:4] == 4'h2) |-> (dmem_bitaddr && !dmem_bank_reg);
  endproperty
  a_bit: assert property (p_bit) else $error("bit area misdecoded");

  property p_app;
    @(posedge ref_clk) disable iff (sys_rst) (pmem_addr[15:9] < 7'h3F) |-> pmem_app_ok;
  endproperty
  a_app: assert property (p_app) else $error("application flash refused");

  property p_xsec;
    @(posedge ref_clk) disable iff (sys_rst) (pmem_addr[15:7] == 9'h100) |-> (pmem_space == MCSI_PM_XSEC && pmem_app_ok);
  endproperty
  a_xsec: assert property (p_xsec) else $error("extra sector not usable");
endmodule

/* bench/mcsi_pin_model.sv */
// mcsi_pin_model.sv: open-drain reset pin with pull-up and a far-side pusher
// assumes: device sinks the line only while rst_pin_oe is high
module mcsi_pin_model (
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic ext_pull,
  output logic pin_level,
  output logic rst_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up wins when nobody sinks the line, so no stale level survives
  assign pin_level = !((rst_pin_oe && !rst_pin_out) || ext_pull);
  assign rst_pin_in = !pin_level;
endmodule

/* bench/mcsi_top_tb_top.sv */
// mcsi_top_tb_top.sv: self-checking bench of mcsi_top
// assumes: mcsi_pkg and mcsi_pin_model compiled before it
module mcsi_top_tb_top import mcsi_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, ext_pull = 1'b0;
  mcsi_rstsrc_t rst_src = 7'h00, rst_enable = 7'h00;
  logic wdog_lock_req = 1'b0, clk_sel_wr = 1'b0, clk_sel_val = 1'b0;
  logic instr_start = 1'b0, instr_branch = 1'b0;
  logic [3:0] instr_lo = 4'h1, instr_hi = 4'h1;
  logic [20:0] irq_src = 21'h000000, irq_ack = 21'h000000;
  logic [7:0] dmem_addr = 8'h00;
  logic dmem_indirect = 1'b0, dbg_halt = 1'b0, dbg_step = 1'b0, dbg_break = 1'b0;
  logic [15:0] xmem_addr = 16'h0000, pmem_addr = 16'h0000;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, core_rst, wdog_locked, clk_sel, pin_level;
  logic instr_busy, instr_done, dmem_bank_reg, dmem_bitaddr, pmem_app_ok, periph_freeze, adc_run;
  logic [3:0] instr_cycles;
  logic [20:0] irq_pend;
  logic [10:0] xram_addr;
  logic [6:0] pmem_sector;
  mcsi_dspace_t dmem_space;
  mcsi_pspace_t pmem_space;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  // addr, indirect, pmem, dspace, bank, bit, pspace
  logic [30:0] rows [7] = '{
    {8'h1F, 1'b0, 16'h0000, 2'h0, 1'b1, 1'b0, 2'h0},
    {8'h20, 1'b1, 16'h7DFF, 2'h0, 1'b0, 1'b1, 2'h0},
    {8'h2F, 1'b0, 16'h7E00, 2'h0, 1'b0, 1'b1, 2'h1},
    {8'h30, 1'b1, 16'h7FFF, 2'h0, 1'b0, 1'b0, 2'h1},
    {8'h80, 1'b1, 16'h8000, 2'h1, 1'b0, 1'b0, 2'h2},
    {8'hFF, 1'b0, 16'h807F, 2'h2, 1'b0, 1'b0, 2'h2},
    {8'h7F, 1'b1, 16'h8080, 2'h0, 1'b0, 1'b0, 2'h3}};

  mcsi_top dut (
    .ref_clk, .sys_rst, .rst_src, .rst_enable, .rst_pin_in, .rst_pin_out, .rst_pin_oe, .core_rst,
    .wdog_lock_req, .wdog_locked, .clk_sel_wr, .clk_sel_val, .clk_sel,
    .instr_start, .instr_lo, .instr_hi, .instr_branch, .instr_busy, .instr_done, .instr_cycles,
    .irq_src, .irq_ack, .irq_pend, .dmem_addr, .dmem_indirect, .dmem_space, .dmem_bank_reg, .dmem_bitaddr,
    .xmem_addr, .xram_addr, .pmem_addr, .pmem_space, .pmem_app_ok, .pmem_sector,
    .dbg_halt, .dbg_step, .dbg_break, .periph_freeze, .adc_run
  );
  mcsi_pin_model pin_model (.rst_pin_out, .rst_pin_oe, .ext_pull, .pin_level, .rst_pin_in);

  always #4 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a wait that ran out of cycles ends the run at once
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic run(input logic [3:0] lo, input logic [3:0] hi, input logic br, input int exp);
    @(posedge ref_clk);
    {instr_lo, instr_hi, instr_branch, instr_start} <= {lo, hi, br, 1'b1};
    // start taken at this edge; a one-clock instruction is done right after it
    @(posedge ref_clk);
    instr_start <= 1'b0;
    n = 1;
    @(negedge ref_clk);
    while (instr_done !== 1'b1 && n < 12) begin
      @(negedge ref_clk);
      n++;
    end
    chk("instr_n", 32'(exp), 32'(n));
    chk("instr_cycles", 32'(exp), 32'(instr_cycles));
    bound(n, 12);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wdog_lock_req <= 1'b1;
    @(posedge ref_clk);
    wdog_lock_req <= 1'b0;
    @(negedge ref_clk);
    chk("rst_pin_oe", 32'h1, 32'(rst_pin_oe));
    chk("pin_level", 32'h0, 32'(pin_level));
    n = 0;
    while (core_rst !== 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    bound(n, 40);
    chk("wdog_locked", 32'h0, 32'(wdog_locked));
    chk("clk_sel", 32'h0, 32'(clk_sel));
    @(posedge ref_clk);
    ext_pull <= 1'b1;
    @(negedge ref_clk);
    chk("core_rst", 32'h1, 32'(core_rst));
    @(posedge ref_clk);
    ext_pull <= 1'b0;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      {dmem_addr, dmem_indirect, pmem_addr} <= rows[i][30:6];
      xmem_addr <= ~rows[i][21:6];
      @(negedge ref_clk);
      chk("dmem_space", 32'(rows[i][5:4]), 32'(dmem_space));
      chk("bank_reg", 32'(rows[i][3]), 32'(dmem_bank_reg));
      chk("bitaddr", 32'(rows[i][2]), 32'(dmem_bitaddr));
      chk("pmem_space", 32'(rows[i][1:0]), 32'(pmem_space));
      chk("app_ok", 32'(rows[i][1:0] == 2'h0 || rows[i][1:0] == 2'h2), 32'(pmem_app_ok));
      chk("sector", 32'(rows[i][21:15]), 32'(pmem_sector));
      chk("xram_addr", 32'(xmem_addr[10:0]), 32'(xram_addr));
    end
    run(4'h3, 4'h5, 1'b0, 3);
    run(4'h3, 4'h5, 1'b1, 5);
    run(4'h1, 4'h2, 1'b0, 1);
    run(4'h8, 4'h8, 1'b1, 8);
    run(4'hC, 4'hC, 1'b1, 8);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      {dbg_break, dbg_step, dbg_halt} <= 3'h1 << i;
      instr_start <= 1'b1;
      @(posedge ref_clk);
      instr_start <= 1'b0;
      @(negedge ref_clk);
      chk("freeze", 32'h1, 32'(periph_freeze));
      chk("adc_run", 32'h1, 32'(adc_run));
      chk("busy", 32'h0, 32'(instr_busy));
    end
    // halt for three edges in mid-instruction: the count must stall
    @(posedge ref_clk);
    {dbg_break, dbg_step, dbg_halt, instr_lo, instr_branch, instr_start} <= {3'h0, 4'h4, 1'b0, 1'b1};
    @(posedge ref_clk);
    {instr_start, dbg_halt} <= 2'h1;
    repeat (3) @(posedge ref_clk);
    dbg_halt <= 1'b0;
    @(negedge ref_clk);
    chk("busy_frz", 32'h1, 32'(instr_busy));
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_done !== 1'b1 && n < 12);
    chk("frz_n", 32'h3, 32'(n));
    bound(n, 12);
    @(posedge ref_clk);
    {dbg_break, dbg_step, dbg_halt, irq_src} <= {3'h0, 21'h1FFFFF};
    @(posedge ref_clk);
    {irq_src, irq_ack} <= {21'h000002, 21'h000003};
    @(negedge ref_clk);
    chk("freeze", 32'h0, 32'(periph_freeze));
    chk("irq_pend", 32'h1FFFFF, 32'(irq_pend));
    @(posedge ref_clk);
    {irq_src, irq_ack} <= 42'h0;
    @(negedge ref_clk);
    chk("irq_pend", 32'h1FFFFE, 32'(irq_pend));
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      {rst_src, rst_enable} <= {7'h01 << i, 7'h00};
      @(negedge ref_clk);
      chk("core_rst_off", 32'(i == 0 || i == 6), 32'(core_rst));
      @(posedge ref_clk);
      rst_enable <= 7'h7F;
      @(negedge ref_clk);
      chk("core_rst_on", 32'h1, 32'(core_rst));
    end
    @(posedge ref_clk);
    {rst_src, rst_enable} <= 14'h0;
    @(posedge ref_clk);
    {wdog_lock_req, clk_sel_wr, clk_sel_val} <= 3'h7;
    @(posedge ref_clk);
    {wdog_lock_req, clk_sel_wr} <= 2'h0;
    @(negedge ref_clk);
    chk("wdog_locked", 32'h1, 32'(wdog_locked));
    chk("clk_sel", 32'h1, 32'(clk_sel));
    @(posedge ref_clk);
    rst_src <= 7'h02;
    @(negedge ref_clk);
    chk("core_rst", 32'h1, 32'(core_rst));
    @(posedge ref_clk);
    rst_src <= 7'h00;
    @(negedge ref_clk);
    chk("clk_sel", 32'h0, 32'(clk_sel));
    chk("wdog_locked", 32'h0, 32'(wdog_locked));
    tally_and_finish();
  end
endmodule
